// *** design/lowpower_ctrl.sv ***
// low-power entry/exit control and per-slot peripheral clock gate map
// assumes an apb master on pclk and a core and interrupt controller on pclk
`timescale 1ns/100ps
module lowpower_ctrl
	import lpwr_pkg::*;
#(
	parameter logic [3:0] HALT_CODE = HALT_CODE_DEFAULT,
	parameter logic [15:0] MISC_RESET = MISC_CONTROL_RESET
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [2:0] pprot,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// core and interrupt controller
	input wire logic [3:0] processor_status_code,
	input wire logic [2:0] irq_level,
	// clock control
	output logic core_clk_en,
	output logic [1:0] lowpower_mode,
	output logic exit_request,
	output logic [GATE_SLOTS-1:0] periph_clk_en
);

	// register state
	logic [7:0] wake_ctl_ff;
	logic [7:0] lp_ctl_ff;
	logic [15:0] misc_ff;
	logic [63:0] map_ff;
	logic [63:0] nxt_map;

	// apb answer flops
	logic [31:0] prdata_ff;
	logic pready_ff;
	logic pslverr_ff;

	// control state
	lp_state_e state_ff;
	lp_state_e nxt_state;
	logic core_clk_en_ff;
	logic nxt_core_clk_en;
	lp_mode_e mode_ff;
	lp_mode_e nxt_mode;
	logic exit_request_ff;
	logic nxt_exit_request;
	logic [GATE_SLOTS-1:0] periph_clk_en_ff;

	// wake path to the evaluator
	wake_if wk ();

	wake_eval u_wake_eval (
		.wk(wk.eval)
	);

	assign wk.irq_level = irq_level;
	assign wk.threshold = wake_ctl_ff[2:0];

	// address decode
	logic hit_wake;
	logic hit_set;
	logic hit_clr;
	logic hit_hi;
	logic hit_lo;
	logic hit_lpc;
	logic hit_misc;
	logic hit_stat;
	logic hit_any;
	logic is_super;
	logic acc_err;

	assign hit_wake = (paddr == ADDR_WAKEUP_CONTROL);
	assign hit_set = (paddr == ADDR_GATE_SET);
	assign hit_clr = (paddr == ADDR_GATE_CLEAR);
	assign hit_hi = (paddr == ADDR_MAP_HIGH);
	assign hit_lo = (paddr == ADDR_MAP_LOW);
	assign hit_lpc = (paddr == ADDR_LOW_POWER_CONTROL);
	assign hit_misc = (paddr == ADDR_MISC_CONTROL);
	assign hit_stat = (paddr == ADDR_LOWPOWER_STATUS);
	assign hit_any = hit_wake | hit_set | hit_clr | hit_hi | hit_lo | hit_lpc | hit_misc
		| hit_stat;

	// pprot[1] high marks a privileged access; everything here is supervisor-only
	assign is_super = pprot[1];
	assign acc_err = ~is_super | ~hit_any;

	// phases: the answer is prepared in setup and presented in the access cycle
	logic setup_ph;
	logic commit;
	logic wr_ok;

	assign setup_ph = psel & ~penable;
	assign commit = psel & penable & pready_ff;
	assign wr_ok = commit & pwrite & ~acc_err;

	// per-register write strobes; narrow registers need lane 0
	logic wr_wake;
	logic wr_set;
	logic wr_clr;
	logic wr_hi;
	logic wr_lo;
	logic wr_lpc;
	logic wr_misc;

	assign wr_wake = wr_ok & hit_wake & pstrb[0];
	assign wr_set = wr_ok & hit_set & pstrb[0];
	assign wr_clr = wr_ok & hit_clr & pstrb[0];
	assign wr_hi = wr_ok & hit_hi;
	assign wr_lo = wr_ok & hit_lo;
	assign wr_lpc = wr_ok & hit_lpc & pstrb[0];
	assign wr_misc = wr_ok & hit_misc;

	// byte lane mask for the 32-bit and 16-bit registers
	logic [31:0] lane_mask;

	assign lane_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

	// set and clear port fields
	logic [5:0] gate_idx;
	logic gate_all;
	logic [63:0] gate_onehot;

	assign gate_idx = pwdata[GATE_INDEX_MSB:0];
	assign gate_all = pwdata[GATE_ALL_BIT];
	// index 0..31 lands in the low word, 32..63 in the high word
	assign gate_onehot = 64'h0000_0000_0000_0001 << gate_idx;

	// map update; only one bus access per cycle so no two sources collide
	always_comb begin
		nxt_map = map_ff;
		if (wr_hi) begin
			nxt_map[63:32] = (map_ff[63:32] & ~lane_mask) | (pwdata & lane_mask);
		end
		if (wr_lo) begin
			nxt_map[31:0] = (map_ff[31:0] & ~lane_mask) | (pwdata & lane_mask);
		end
		if (wr_set) begin
			if (gate_all) begin
				nxt_map = {64{1'b1}};
			end else begin
				nxt_map = map_ff | gate_onehot;
			end
		end
		if (wr_clr) begin
			if (gate_all) begin
				nxt_map = GATE_MAP_RESET;
			end else begin
				nxt_map = map_ff & ~gate_onehot;
			end
		end
	end

	// read mux; the write-only ports return zero
	logic [31:0] rd_wake;
	logic [31:0] rd_lpc;
	logic [31:0] rd_misc;
	logic [31:0] rd_stat;
	logic [31:0] rd_data;

	assign rd_wake = {24'h00_0000, wake_ctl_ff};
	assign rd_lpc = {24'h00_0000, lp_ctl_ff};
	assign rd_misc = {16'h0000, misc_ff};
	// status packs seven bits, so the pad is 25 wide
	assign rd_stat = {25'h000_0000, exit_request_ff, state_ff, mode_ff, core_clk_en_ff};
	assign rd_data = acc_err ? 32'h0000_0000 :
		hit_wake ? rd_wake :
		hit_hi ? map_ff[63:32] :
		hit_lo ? map_ff[31:0] :
		hit_lpc ? rd_lpc :
		hit_misc ? rd_misc :
		hit_stat ? rd_stat :
		32'h0000_0000;

	// answer flops: ready rises in the access cycle, so no wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
		end else begin
			pready_ff <= setup_ph;
			pslverr_ff <= setup_ph & acc_err;
			prdata_ff <= (setup_ph & ~pwrite) ? rd_data : 32'h0000_0000;
		end
	end

	// software registers; reserved wakeup bits never store
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_ctl_ff <= WAKEUP_CONTROL_RESET;
			lp_ctl_ff <= LOW_POWER_CONTROL_RESET;
			misc_ff <= MISC_RESET; // reset value is a parameter, so a chip can pick its own
		end else begin
			if (wr_wake) begin
				wake_ctl_ff <= pwdata[7:0] & WAKE_WRITE_MASK;
			end
			if (wr_lpc) begin
				lp_ctl_ff <= pwdata[7:0];
			end
			if (wr_misc) begin
				misc_ff <= (misc_ff & ~lane_mask[15:0]) | (pwdata[15:0] & lane_mask[15:0]);
			end
		end
	end

	// gate map
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			map_ff <= GATE_MAP_RESET;
		end else begin
			map_ff <= nxt_map;
		end
	end

	// entry conditions
	logic entry_en;
	logic core_halted;
	lp_mode_e sel_mode;

	assign entry_en = wake_ctl_ff[WAKE_ENTRY_EN_BIT];
	assign core_halted = (processor_status_code == HALT_CODE);
	assign sel_mode = lp_mode_e'(lp_ctl_ff[LP_SELECT_LSB +: 2]);

	// low-power sequencer
	always_comb begin
		nxt_state = state_ff;
		nxt_core_clk_en = core_clk_en_ff;
		nxt_mode = mode_ff;
		nxt_exit_request = exit_request_ff;
		case (state_ff)
			ST_RUN: begin
				// a halt with entry blocked leaves every clock running
				if (core_halted && entry_en) begin
					if (sel_mode == LP_RUN) begin
						nxt_state = ST_HALT;
					end else begin
						nxt_state = ST_LOWPOWER;
						nxt_mode = sel_mode;
						nxt_core_clk_en = 1'b0;
					end
				end
			end
			ST_HALT: begin
				// run select: core stopped but no clock is disabled
				if (wk.wake_ok) begin
					nxt_state = ST_RESUME;
					nxt_exit_request = 1'b1;
				end else if (!core_halted) begin
					nxt_state = ST_RUN;
				end
			end
			ST_LOWPOWER: begin
				if (wk.wake_ok) begin
					nxt_state = ST_EXIT_REQ;
					nxt_exit_request = 1'b1;
				end
			end
			ST_EXIT_REQ: begin
				// core clock comes back one cycle after the exit request, stop-parked peripheral clocks one cycle later
				nxt_state = ST_RESUME;
				nxt_core_clk_en = 1'b1;
				nxt_mode = LP_RUN;
			end
			ST_RESUME: begin
				// hold the request until the core leaves its halt to service it
				if (!core_halted) begin
					nxt_state = ST_RUN;
					nxt_exit_request = 1'b0;
				end
			end
			default: begin
				nxt_state = ST_RUN;
				nxt_core_clk_en = 1'b1;
				nxt_mode = LP_RUN;
				nxt_exit_request = 1'b0;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= ST_RUN;
			core_clk_en_ff <= 1'b1;
			mode_ff <= LP_RUN;
			exit_request_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			core_clk_en_ff <= nxt_core_clk_en;
			mode_ff <= nxt_mode;
			exit_request_ff <= nxt_exit_request;
		end
	end

	// stop mode also parks every peripheral clock; the map is left untouched
	logic stop_park;

	assign stop_park = (mode_ff == LP_STOP);

	// one gate enable flop per slot
	genvar gi;
	generate
		for (gi = 0; gi < GATE_SLOTS; gi++) begin : g_slot
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					periph_clk_en_ff[gi] <= 1'b1;
				end else begin
					periph_clk_en_ff[gi] <= ~nxt_map[gi] & ~stop_park;
				end
			end
		end
	endgenerate

	// outputs straight from flops
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign core_clk_en = core_clk_en_ff;
	assign lowpower_mode = mode_ff;
	assign exit_request = exit_request_ff;
	assign periph_clk_en = periph_clk_en_ff;

endmodule

// *** common/lpwr_pkg.sv ***
// constants, field layouts and state encodings for the low-power control block
// assumes a 32-bit apb with byte addresses equal to four times a register index
package lpwr_pkg;

	// register indices as printed; the byte address is four times the index
	localparam logic [31:0] IDX_WAKEUP_CONTROL = 32'hfc04_0013;
	localparam logic [31:0] IDX_CLOCK_GATE_SET_PORT = 32'hfc04_002c;
	localparam logic [31:0] IDX_CLOCK_GATE_CLEAR_PORT = 32'hfc04_002d;
	localparam logic [31:0] IDX_CLOCK_GATE_MAP_HIGH = 32'hfc04_0030;
	localparam logic [31:0] IDX_CLOCK_GATE_MAP_LOW = 32'hfc04_0034;
	localparam logic [31:0] IDX_LOW_POWER_CONTROL = 32'hfc0a_0007;
	localparam logic [31:0] IDX_MISCELLANEOUS_CONTROL = 32'hfc0a_0010;
	localparam logic [31:0] IDX_LOWPOWER_STATUS = 32'hfc04_0038;

	// byte addresses; the top two index bits fall off a 32-bit bus
	localparam logic [31:0] ADDR_WAKEUP_CONTROL = {IDX_WAKEUP_CONTROL[29:0], 2'b00};
	localparam logic [31:0] ADDR_GATE_SET = {IDX_CLOCK_GATE_SET_PORT[29:0], 2'b00};
	localparam logic [31:0] ADDR_GATE_CLEAR = {IDX_CLOCK_GATE_CLEAR_PORT[29:0], 2'b00};
	localparam logic [31:0] ADDR_MAP_HIGH = {IDX_CLOCK_GATE_MAP_HIGH[29:0], 2'b00};
	localparam logic [31:0] ADDR_MAP_LOW = {IDX_CLOCK_GATE_MAP_LOW[29:0], 2'b00};
	localparam logic [31:0] ADDR_LOW_POWER_CONTROL = {IDX_LOW_POWER_CONTROL[29:0], 2'b00};
	localparam logic [31:0] ADDR_MISC_CONTROL = {IDX_MISCELLANEOUS_CONTROL[29:0], 2'b00};
	localparam logic [31:0] ADDR_LOWPOWER_STATUS = {IDX_LOWPOWER_STATUS[29:0], 2'b00};

	// field positions and masks
	localparam int WAKE_ENTRY_EN_BIT = 7;
	localparam logic [7:0] WAKE_WRITE_MASK = 8'h87;
	localparam int GATE_INDEX_MSB = 5;
	localparam int GATE_ALL_BIT = 6;
	localparam int LP_SELECT_LSB = 6;
	localparam int GATE_SLOTS = 64;

	// reset values
	localparam logic [7:0] WAKEUP_CONTROL_RESET = 8'h00;
	localparam logic [7:0] LOW_POWER_CONTROL_RESET = 8'h00;
	localparam logic [15:0] MISC_CONTROL_RESET = 16'h0000;
	localparam logic [63:0] GATE_MAP_RESET = 64'h0000_0000_0000_0000;

	// threshold decode points
	localparam logic [2:0] THR_ANY = 3'h0;
	localparam logic [2:0] THR_TOP = 3'h6;
	localparam logic [2:0] LEVEL_MAX = 3'h7;
	localparam logic [2:0] LEVEL_NONE = 3'h0;

	// processor status code that reports a halt on the stop instruction; value is arbitrary
	localparam logic [3:0] HALT_CODE_DEFAULT = 4'he;

	typedef enum logic [1:0] {
		LP_RUN = 2'b00,
		LP_DOZE = 2'b01,
		LP_WAIT = 2'b10,
		LP_STOP = 2'b11
	} lp_mode_e;

	typedef enum logic [2:0] {
		ST_RUN = 3'b000,
		ST_HALT = 3'b001,
		ST_LOWPOWER = 3'b010,
		ST_EXIT_REQ = 3'b011,
		ST_RESUME = 3'b100
	} lp_state_e;

endpackage

// *** common/wake_if.sv ***
// carries the pending request level and threshold to the wake evaluator
// assumes both ends sit on the same clock; the path itself is combinational
`timescale 1ns/100ps
interface wake_if;
	logic [2:0] irq_level;
	logic [2:0] threshold;
	logic wake_ok;

	modport ctrl (output irq_level, output threshold, input wake_ok);
	modport eval (input irq_level, input threshold, output wake_ok);
endinterface

// *** design/wake_eval.sv ***
// wake qualifier: compares the pending request level with the threshold
// assumes level 0 means no request; works without any clock
`timescale 1ns/100ps
module wake_eval
	import lpwr_pkg::*;
(
	// link to the controller
	wake_if.eval wk
);

	logic [2:0] need_level;
	logic thr_any;
	logic thr_top;

	// needed level: any, threshold plus one, or only the top level
	assign thr_any = (wk.threshold == THR_ANY);
	assign thr_top = (wk.threshold >= THR_TOP);
	assign need_level = thr_top ? LEVEL_MAX : 3'(wk.threshold + 3'h1);

	// pure gates so it still answers while the core clock is stopped
	assign wk.wake_ok = (wk.irq_level != LEVEL_NONE) &
		(thr_any | (wk.irq_level >= need_level));

endmodule

// *** sim/lowpower_ctrl_props.sv ***
// port assertions for the low-power block
// assumes lane 0 always strobed; shadows the entry and wake fields
`timescale 1ns/100ps
module lowpower_ctrl_props
	import lpwr_pkg::*;
#(
	parameter logic [3:0] HALT_CODE = HALT_CODE_DEFAULT
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [2:0] pprot,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// core side
	input wire logic [3:0] processor_status_code,
	input wire logic [2:0] irq_level,
	input wire logic core_clk_en,
	input wire logic [1:0] lowpower_mode,
	input wire logic exit_request
);
	logic en_ff;
	logic [2:0] thr_ff;
	logic [1:0] sel_ff;
	// commit decode and the threshold compare, level 0 never wakes
	wire wr = psel && penable && pready && pwrite && pprot[1];
	wire halted = processor_status_code == HALT_CODE;
	wire asleep = !core_clk_en && !exit_request;
	wire wk = irq_level != 3'h0 && (thr_ff >= 3'h6 ? irq_level == 3'h7 : irq_level > thr_ff);
	// shadow only what steers entry and wake
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_ff <= 1'b0;
			thr_ff <= 3'h0;
			sel_ff <= 2'b00;
		end else if (wr && paddr == ADDR_WAKEUP_CONTROL) begin
			en_ff <= pwdata[7];
			thr_ff <= pwdata[2:0];
		end else if (wr && paddr == ADDR_LOW_POWER_CONTROL) begin
			sel_ff <= pwdata[7:6];
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_user_error: assert property (psel && penable && !pprot[1] |-> pready && pslverr)
		else $error("user access not refused");
	a_entry_block: assert property (halted && !en_ff && core_clk_en && !exit_request
		|=> core_clk_en && lowpower_mode == 2'b00) else $error("entry not blocked");
	a_entry_mode: assert property (halted && en_ff && sel_ff != 2'b00 && core_clk_en
		&& !exit_request |=> !core_clk_en && lowpower_mode == sel_ff) else $error("bad entry");
	a_no_wake: assert property (asleep && !wk |=> !exit_request)
		else $error("wake below threshold");
	a_wake_req: assert property (asleep && wk |=> exit_request)
		else $error("no exit request");
	a_clk_back: assert property (!core_clk_en && exit_request
		|=> core_clk_en && lowpower_mode == 2'b00) else $error("clocks not restored");
	a_exit_drop: assert property (exit_request && !halted |=> !exit_request)
		else $error("exit request stuck");
	a_port_zero: assert property (psel && penable && !pwrite && (paddr == ADDR_GATE_SET
		|| paddr == ADDR_GATE_CLEAR) |-> prdata == 32'h0000_0000) else $error("port read not 0");
	c_wake: cover property ($rose(exit_request));
	c_refused: cover property (psel && penable && pslverr);
	c_stop: cover property ($fell(core_clk_en) && lowpower_mode == 2'b11);
endmodule

bind lowpower_ctrl lowpower_ctrl_props #(.HALT_CODE(HALT_CODE)) lowpower_ctrl_props_i (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pprot(pprot), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .processor_status_code(processor_status_code), .irq_level(irq_level),
	.core_clk_en(core_clk_en), .lowpower_mode(lowpower_mode), .exit_request(exit_request));

// *** sim/core_irq_model.sv ***
// core and interrupt controller stand-in on the far side
// assumes bench commands on pclk; halts on stop_cmd until woken
`timescale 1ns/100ps
module core_irq_model
	import lpwr_pkg::*;
#(
	parameter logic [3:0] HALT_CODE = HALT_CODE_DEFAULT
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// bench commands
	input wire logic stop_cmd,
	input wire logic [2:0] irq_cmd,
	input wire logic [1:0] lag,
	// block side
	input wire logic core_clk_en,
	input wire logic exit_request,
	output logic [3:0] processor_status_code,
	output logic [2:0] irq_level
);
	logic halted_ff;
	logic [1:0] cnt_ff;
	// halt code only while stopped; requests only matter while halted
	assign processor_status_code = halted_ff ? HALT_CODE : 4'h0;
	assign irq_level = halted_ff ? irq_cmd : 3'h0;
	// lag lets the core resume promptly or slowly once clocked again
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			halted_ff <= 1'b0;
			cnt_ff <= 2'b00;
		end else if (!halted_ff) begin
			halted_ff <= stop_cmd;
			cnt_ff <= 2'b00;
		end else if (core_clk_en && exit_request) begin
			halted_ff <= cnt_ff != lag;
			cnt_ff <= cnt_ff + 2'b01;
		end
	end
endmodule

// *** sim/tb.sv ***
// self-checking bench for the low-power block
// assumes the core model on the far side; apb driven from here
`timescale 1ns/100ps
module tb
	import lpwr_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = 32'h0000_0000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [2:0] pprot = 3'h2;
	logic stop_cmd = 1'b0;
	logic [2:0] irq_cmd = 3'h0;
	logic [1:0] lag = 2'b00;
	logic [3:0] processor_status_code;
	logic [2:0] irq_level;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic core_clk_en;
	logic [1:0] lowpower_mode;
	logic exit_request;
	logic [63:0] periph_clk_en;
	logic [31:0] rd;
	logic er;
	int error_cnt = 0;
	int compares = 0;
	logic [5:0] ix_t [4] = '{6'h00, 6'h1f, 6'h20, 6'h3f};
	logic [2:0] thr_t [6] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h6, 3'h7};
	logic [2:0] lo_t [6] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h6, 3'h6};
	logic [2:0] hi_t [6] = '{3'h1, 3'h2, 3'h4, 3'h6, 3'h7, 3'h7};

	// 100 MHz
	always #5 pclk = ~pclk;

	lowpower_ctrl lowpower_ctrl_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .pprot(pprot), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .processor_status_code(processor_status_code),
		.irq_level(irq_level), .core_clk_en(core_clk_en), .lowpower_mode(lowpower_mode),
		.exit_request(exit_request), .periph_clk_en(periph_clk_en));
	core_irq_model core_irq_model_i (
		.pclk(pclk), .presetn(presetn), .stop_cmd(stop_cmd), .irq_cmd(irq_cmd), .lag(lag),
		.core_clk_en(core_clk_en), .exit_request(exit_request),
		.processor_status_code(processor_status_code), .irq_level(irq_level));

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic close_out;
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// a hung handshake ends the run as a mismatch
	task automatic fail_wait;
		error_cnt++;
		$display("[ERR] %0t wait ran out", $time);
		close_out();
	endtask
	// one transfer held until pready; two idle edges let registered outputs land
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
		input logic [2:0] pr);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pprot <= pr;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
			if (n > 16) fail_wait();
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 3'h2);
	endtask
	task automatic rdc(input logic [31:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000, 3'h2);
		chk({32'h0, rd}, {32'h0, e});
	endtask
	// bounded wait on core clock enable (k 0) or exit request (k 1)
	task automatic wait_on(input int k, input logic v);
		int n;
		n = 0;
		while ((k == 0 ? core_clk_en : exit_request) !== v) begin
			@(posedge pclk);
			n++;
			if (n > 50) fail_wait();
		end
	endtask
	task automatic stop_pulse;
		stop_cmd <= 1'b1;
		@(posedge pclk);
		stop_cmd <= 1'b0;
	endtask

	task automatic t_reset;
		rdc(ADDR_WAKEUP_CONTROL, 32'h0000_0000);
		rdc(ADDR_LOW_POWER_CONTROL, 32'h0000_0000);
		rdc(ADDR_MAP_HIGH, 32'h0000_0000);
		rdc(ADDR_MAP_LOW, 32'h0000_0000);
		rdc(ADDR_MISC_CONTROL, 32'h0000_0000);
		chk(periph_clk_en, ~64'h0);
		$display("t_reset done");
	endtask
	task automatic t_access;
		apb(1'b1, ADDR_WAKEUP_CONTROL, 32'h0000_0085, 3'h0);
		chk({63'h0, er}, 64'h1);
		rdc(ADDR_WAKEUP_CONTROL, 32'h0000_0000);
		apb(1'b0, 32'h0000_0100, 32'h0000_0000, 3'h2);
		chk({63'h0, er}, 64'h1);
		wr(ADDR_WAKEUP_CONTROL, 32'h0000_00ff);
		rdc(ADDR_WAKEUP_CONTROL, 32'h0000_0087);
		wr(ADDR_MAP_LOW, 32'h1234_5678);
		rdc(ADDR_MAP_LOW, 32'h1234_5678);
		wr(ADDR_GATE_SET, 32'h0000_0005);
		rdc(ADDR_GATE_SET, 32'h0000_0000);
		rdc(ADDR_GATE_CLEAR, 32'h0000_0000);
		wr(ADDR_GATE_CLEAR, 32'h0000_0040);
		$display("t_access done");
	endtask
	task automatic t_gates;
		logic [63:0] m;
		m = 64'h0;
		foreach (ix_t[j]) begin
			wr(ADDR_GATE_SET, {26'h0, ix_t[j]});
			m[ix_t[j]] = 1'b1;
			chk(periph_clk_en, ~m);
		end
		rdc(ADDR_MAP_LOW, m[31:0]);
		rdc(ADDR_MAP_HIGH, m[63:32]);
		wr(ADDR_GATE_CLEAR, 32'h0000_0020);
		m[32] = 1'b0;
		rdc(ADDR_MAP_HIGH, m[63:32]);
		wr(ADDR_GATE_SET, 32'h0000_007f);
		chk(periph_clk_en, 64'h0);
		wr(ADDR_GATE_CLEAR, 32'h0000_0040);
		chk(periph_clk_en, ~64'h0);
		wr(ADDR_GATE_SET, 32'h0000_0040);
		wr(ADDR_GATE_CLEAR, 32'h0000_007f);
		rdc(ADDR_MAP_LOW, 32'h0000_0000);
		$display("t_gates done");
	endtask
	// every select and six threshold settings: enter, stay asleep at the highest level that must not wake, wake at the lowest that must
	task automatic t_modes;
		logic [1:0] sel;
		foreach (thr_t[i]) begin
			sel = 2'(i + 1);
			lag <= 2'(i);
			wr(ADDR_WAKEUP_CONTROL, {24'h0, 5'h10, thr_t[i]});
			wr(ADDR_LOW_POWER_CONTROL, {24'h0, sel, 6'h0});
			stop_pulse();
			if (sel != 2'b00) wait_on(0, 1'b0);
			else repeat (3) @(posedge pclk);
			chk({62'h0, lowpower_mode}, {62'h0, sel});
			irq_cmd <= lo_t[i];
			repeat (4) @(posedge pclk);
			chk({63'h0, exit_request}, 64'h0);
			chk(periph_clk_en, (sel == 2'b11) ? 64'h0 : ~64'h0);
			irq_cmd <= hi_t[i];
			wait_on(1, 1'b1);
			wait_on(1, 1'b0);
			chk({61'h0, core_clk_en, lowpower_mode}, 64'h4);
			irq_cmd <= 3'h0;
		end
		$display("t_modes done");
	endtask
	// halt with entry off, then a reset in mid-run
	task automatic t_blocked;
		wr(ADDR_WAKEUP_CONTROL, 32'h0000_0007);
		wr(ADDR_LOW_POWER_CONTROL, 32'h0000_00c0);
		stop_pulse();
		irq_cmd <= 3'h7;
		repeat (5) @(posedge pclk);
		chk({60'h0, exit_request, core_clk_en, lowpower_mode}, 64'h4);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		irq_cmd <= 3'h0;
		@(posedge pclk);
		chk({60'h0, exit_request, core_clk_en, lowpower_mode}, 64'h4);
		rdc(ADDR_LOW_POWER_CONTROL, 32'h0000_0000);
		$display("t_blocked done");
	endtask

	// reset for three cycles, then the scenarios in turn
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_access();
		t_gates();
		t_modes();
		t_blocked();
		close_out();
	end
endmodule
